/* rtl/ppc_map.svh */
`ifndef PPC_MAP_SVH
`define PPC_MAP_SVH

// ***********************************************************
// bus timing
// ***********************************************************
`define PPC_DEVSEL_WAIT 3'h5
`define PPC_REQ_GAP     2'h2

// ***********************************************************
// command and decode values
// ***********************************************************
`define PPC_CMD_CFG_RD  4'ha
`define PPC_CMD_CFG_WR  4'hb
`define PPC_CFG_TYPE0   2'h0
`define PPC_PARK_AD     32'h0000_0000
`define PPC_PARK_CBE    4'h0
`define PPC_INACTIVE    1'h1

`endif

/* rtl/ppc_pkg.sv */
package ppc_pkg;

  // ***********************************************************
  // port sequencer states
  // ***********************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_M_ADDR,
    ST_M_DATA,
    ST_M_WAIT,
    ST_M_TURN,
    ST_T_DEVSEL,
    ST_T_DATA,
    ST_T_END
  } ppc_state_e;

  typedef logic [5:0] ppc_cfg_reg_t;

endpackage : ppc_pkg

/* rtl/ppc_sts_drv.sv */
`timescale 1ns/10ps
`include "ppc_map.svh"

module ppc_sts_drv (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // intent from the port sequencer
  input  wire logic drive_en,
  input  wire logic assert_lvl,
  // pin
  output logic      pin_drv_q,
  output logic      pin_oe_q
);

  logic park_q;

  // releasing always costs one extra cycle driven high
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_drv_q <= `PPC_INACTIVE;
      pin_oe_q  <= 1'h0;
      park_q    <= 1'h0;
    end else begin
      pin_oe_q  <= drive_en | (pin_oe_q & ~park_q);
      pin_drv_q <= ~(drive_en & assert_lvl);
      park_q    <= ~drive_en & pin_oe_q & ~park_q;
    end
  end

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_park_high;
    pin_oe_q && pin_drv_q;
  endsequence

  property p_park_before_release;
    pin_oe_q && !park_q && !drive_en |=> s_park_high ##1 !pin_oe_q;
  endproperty
  a_park_before_release: assert property (p_park_before_release)
    else $error("line released without one inactive cycle");

  property p_oe_fall;
    $fell(pin_oe_q) |-> $past(pin_drv_q) && $past(pin_oe_q, 2);
  endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("line floated straight from an active drive");

endmodule : ppc_sts_drv

/* rtl/ppc_port.sv */
`timescale 1ns/10ps
`include "ppc_map.svh"

module ppc_port
  import ppc_pkg::*;
#(
  parameter int N_SERR_EV = 6
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // primary address, command and parity
  input  wire logic [31:0]          pci_ad_bus,
  output logic      [31:0]          pci_ad_drv,
  output logic                      pci_ad_oe,
  input  wire logic [3:0]           pci_cbe_bus,
  output logic      [3:0]           pci_cbe_drv,
  output logic                      pci_cbe_oe,
  input  wire logic                 pci_par_bus,
  output logic                      pci_par_drv,
  output logic                      pci_par_oe,
  // primary control lines
  input  wire logic                 pci_frame_n_bus,
  output logic                      pci_frame_n_drv,
  output logic                      pci_frame_n_oe,
  input  wire logic                 pci_irdy_n_bus,
  output logic                      pci_irdy_n_drv,
  output logic                      pci_irdy_n_oe,
  input  wire logic                 pci_trdy_n_bus,
  output logic                      pci_trdy_n_drv,
  output logic                      pci_trdy_n_oe,
  input  wire logic                 pci_devsel_n_bus,
  output logic                      pci_devsel_n_drv,
  output logic                      pci_devsel_n_oe,
  input  wire logic                 pci_stop_n_bus,
  output logic                      pci_stop_n_drv,
  output logic                      pci_stop_n_oe,
  input  wire logic                 pci_lock_n_bus,
  output logic                      pci_lock_n_drv,
  output logic                      pci_lock_n_oe,
  // error lines
  input  wire logic                 primary_parity_error_n_bus,
  output logic                      primary_parity_error_n_drv,
  output logic                      primary_parity_error_n_oe,
  input  wire logic                 primary_system_error_n_bus,
  output logic                      primary_system_error_n_drv,
  output logic                      primary_system_error_n_oe,
  // arbitration and select
  output logic                      pci_req_n_drv,
  output logic                      pci_req_n_oe,
  input  wire logic                 pci_gnt_n,
  input  wire logic                 primary_config_select,
  // speed straps and status
  input  wire logic                 primary_speed_select_in,
  input  wire logic                 sec_one_speed_select_in,
  input  wire logic                 sec_two_speed_select_in,
  output logic                      speed_66,
  output logic                      speed_conflict,
  // system error sources
  input  wire logic                 sec_one_system_error_n,
  input  wire logic                 sec_two_system_error_n,
  input  wire logic [N_SERR_EV-1:0] serr_event,
  // master request side
  input  wire logic                 mst_req,
  input  wire logic [3:0]           mst_cmd,
  input  wire logic [31:0]          mst_addr,
  input  wire logic [31:0]          mst_wdata,
  input  wire logic [3:0]           mst_be,
  input  wire logic                 mst_last,
  input  wire logic                 mst_lock,
  output logic                      mst_ack,
  output logic      [31:0]          mst_rdata,
  output logic                      mst_done,
  output logic                      mst_abort,
  output logic                      mst_stopped,
  // configuration target side
  input  wire logic [31:0]          cfg_rdata,
  output logic                      cfg_wr,
  output logic                      cfg_rd,
  output ppc_cfg_reg_t              cfg_reg,
  output logic      [31:0]          cfg_wdata,
  output logic      [3:0]           cfg_be
);

  // ***********************************************************
  // state
  // ***********************************************************
  ppc_state_e   st_q, st_d;
  logic [2:0]   dcnt_q;
  logic [1:0]   gap_q;
  logic [31:0]  ad_q, ad_d, rdata_q, wdata_q;
  logic [3:0]   cbe_q, cbe_d, be_q;
  ppc_cfg_reg_t reg_q;
  logic         ad_oe_q, cbe_oe_q, par_q, par_oe_q, req_n_q, req_oe_q;
  logic         claimed_q, last_q, last_d, write_q, stop_seen_q;
  logic         tgt_rd_q, tdone_q, lock_held_q, frame_prev_q;
  logic         chk_q, chk_en_q, achk_q, achk_en_q, serr_oe_q, serr_q;
  logic         ack_q, done_q, abort_q, stopped_q, cwr_q, crd_q;
  logic         spd_q, conf_q;
  logic [6:0]   sts_en, sts_act, sts_drv, sts_oe;

  // ***********************************************************
  // decode
  // ***********************************************************
  wire granted   = ~pci_gnt_n;
  wire bus_idle  = pci_frame_n_bus & pci_irdy_n_bus;
  wire xfer      = ~pci_irdy_n_bus & ~pci_trdy_n_bus;
  wire m_stop    = ~pci_stop_n_bus;
  wire m_claim   = claimed_q | ~pci_devsel_n_bus;
  wire m_tmo     = ~m_claim & (dcnt_q == `PPC_DEVSEL_WAIT);
  wire idle      = (st_q == ST_IDLE);
  wire addr_ph   = idle & ~pci_frame_n_bus & frame_prev_q;
  wire cfg_cmd   = (pci_cbe_bus == `PPC_CMD_CFG_RD) |
                   (pci_cbe_bus == `PPC_CMD_CFG_WR);
  wire cfg_hit   = addr_ph & primary_config_select & cfg_cmd &
                   (pci_ad_bus[1:0] == `PPC_CFG_TYPE0);
  // start only when granted and the lock is free or ours
  wire m_start   = idle & mst_req & granted & bus_idle & ~addr_ph &
                   (pci_lock_n_bus | lock_held_q);
  wire m_end     = (st_q == ST_M_DATA) & (xfer | m_stop | m_tmo) & last_q;
  wire m_act     = (st_d == ST_M_DATA) | (st_d == ST_M_WAIT);
  wire t_act     = (st_d == ST_T_DEVSEL) | (st_d == ST_T_DATA);
  wire tdone_d   = (st_q == ST_T_DATA) & (tdone_q | xfer);
  wire park      = (st_d == ST_IDLE) & granted & bus_idle;
  wire recv      = xfer & (((st_q == ST_M_DATA) & ~write_q) |
                   ((st_q == ST_T_DATA) & ~tgt_rd_q & ~tdone_q));
  wire perr_hit  = chk_en_q & (chk_q ^ pci_par_bus);
  wire aperr_hit = achk_en_q & (achk_q ^ pci_par_bus);
  wire serr_hit  = aperr_hit | ~sec_one_system_error_n |
                   ~sec_two_system_error_n | (|serr_event);
  wire lock_d    = (m_start & mst_lock) | (lock_held_q & ~(idle & ~mst_lock));
  wire [3:0] cbe_seen = cbe_oe_q ? cbe_q : pci_cbe_bus;

  // ***********************************************************
  // sequencer
  // ***********************************************************
  always_comb begin
    st_d   = st_q;
    last_d = last_q;
    case (st_q)
      ST_IDLE: begin
        if (m_start) begin
          st_d = ST_M_ADDR;
        end else if (cfg_hit) begin
          st_d = ST_T_DEVSEL;
        end
      end
      ST_M_ADDR: begin
        st_d   = ST_M_DATA;
        last_d = mst_last;
      end
      ST_M_DATA: begin
        // stop or timeout first drops frame, then ends
        if (m_end) begin
          st_d = ST_M_TURN;
        end else if (m_stop | m_tmo) begin
          last_d = 1'h1;
        end else if (xfer) begin
          st_d = ST_M_WAIT;
        end
      end
      ST_M_WAIT: begin
        st_d   = ST_M_DATA;
        last_d = mst_last;
      end
      ST_T_DEVSEL: st_d = ST_T_DATA;
      ST_T_DATA: begin
        if (tdone_d & pci_frame_n_bus) begin
          st_d = ST_T_END;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // ***********************************************************
  // pin intents, taken from next state so pins move with it
  // ***********************************************************
  // order: frame, irdy, trdy, devsel, stop, lock, perr
  assign sts_en  = {perr_hit, lock_d, t_act, t_act, t_act, m_act,
                    m_act | (st_d == ST_M_ADDR)};
  assign sts_act = {1'h1, 1'h1, (st_d == ST_T_DATA) & ~pci_frame_n_bus,
                    1'h1, (st_d == ST_T_DATA) & ~tdone_d,
                    st_d == ST_M_DATA,
                    (st_d == ST_M_ADDR) | (st_d == ST_M_WAIT) |
                    ((st_d == ST_M_DATA) & ~last_d)};

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_sts
      ppc_sts_drv u_sts (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .drive_en   (sts_en[gi]),
        .assert_lvl (sts_act[gi]),
        .pin_drv_q  (sts_drv[gi]),
        .pin_oe_q   (sts_oe[gi])
      );
    end
  endgenerate

  // address/data and command mux
  always_comb begin
    ad_d  = `PPC_PARK_AD;
    cbe_d = `PPC_PARK_CBE;
    if (st_d == ST_M_ADDR) begin
      ad_d  = mst_addr;
      cbe_d = mst_cmd;
    end else if (m_act) begin
      ad_d  = mst_wdata;
      cbe_d = mst_be;
    end else if (st_d == ST_T_DATA) begin
      ad_d  = cfg_rdata;
    end
  end

  wire ad_oe_d  = park | (st_d == ST_M_ADDR) | (m_act & write_q) |
                  ((st_d == ST_T_DATA) & tgt_rd_q);
  wire cbe_oe_d = park | (st_d == ST_M_ADDR) | m_act;

  // ***********************************************************
  // registers; reset floats every bus output at once
  // ***********************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      {ad_q, cbe_q, ad_oe_q, cbe_oe_q, par_q, par_oe_q} <= '0;
      {req_oe_q, serr_oe_q, serr_q, chk_q, chk_en_q} <= '0;
      {achk_q, achk_en_q, claimed_q, last_q, write_q} <= '0;
      {stop_seen_q, tgt_rd_q, tdone_q, lock_held_q} <= '0;
      {ack_q, done_q, abort_q, stopped_q, cwr_q, crd_q} <= '0;
      {rdata_q, wdata_q, be_q, reg_q, spd_q, conf_q, dcnt_q, gap_q} <= '0;
      req_n_q      <= `PPC_INACTIVE;
      frame_prev_q <= `PPC_INACTIVE;
    end else begin
      st_q         <= st_d;
      last_q       <= last_d;
      frame_prev_q <= pci_frame_n_bus;
      ad_q         <= ad_d;
      cbe_q        <= cbe_d;
      ad_oe_q      <= ad_oe_d;
      cbe_oe_q     <= cbe_oe_d;
      par_q        <= ^{ad_q, cbe_seen};
      par_oe_q     <= ad_oe_q;
      lock_held_q  <= lock_d;
      tdone_q      <= tdone_d;
      req_oe_q     <= 1'h1;
      chk_en_q     <= recv;
      chk_q        <= ^{pci_ad_bus, pci_cbe_bus};
      achk_en_q    <= addr_ph;
      achk_q       <= ^{pci_ad_bus, pci_cbe_bus};
      serr_oe_q    <= serr_hit;
      spd_q        <= primary_speed_select_in;
      conf_q       <= ~primary_speed_select_in &
                      (sec_one_speed_select_in | sec_two_speed_select_in);
      if (m_start) begin
        write_q <= mst_cmd[0];
      end
      if (cfg_hit) begin
        tgt_rd_q <= ~pci_cbe_bus[0];
        reg_q    <= pci_ad_bus[7:2];
      end
      if (st_q == ST_M_ADDR) begin
        dcnt_q      <= 3'h1;
        claimed_q   <= 1'h0;
        stop_seen_q <= 1'h0;
      end else begin
        if (dcnt_q != `PPC_DEVSEL_WAIT) begin
          dcnt_q <= dcnt_q + 3'h1;
        end
        claimed_q   <= m_claim;
        stop_seen_q <= stop_seen_q | ((st_q == ST_M_DATA) & m_stop);
      end
      // request pacing
      if (~req_n_q & (m_start | ~mst_req)) begin
        req_n_q <= `PPC_INACTIVE;
        gap_q   <= `PPC_REQ_GAP;
      end else if (req_n_q & mst_req & idle & (gap_q == 2'h0) & ~granted) begin
        req_n_q <= 1'h0;
      end else if (gap_q != 2'h0) begin
        gap_q <= gap_q - 2'h1;
      end
      ack_q     <= (st_q == ST_M_DATA) & xfer;
      done_q    <= m_end;
      abort_q   <= m_end & ~m_claim;
      stopped_q <= m_end & (m_stop | stop_seen_q);
      if ((st_q == ST_M_DATA) & xfer) begin
        rdata_q <= pci_ad_bus;
      end
      cwr_q <= recv & (st_q == ST_T_DATA);
      crd_q <= cfg_hit & ~pci_cbe_bus[0];
      if (recv & (st_q == ST_T_DATA)) begin
        wdata_q <= pci_ad_bus;
        be_q    <= pci_cbe_bus;
      end
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  assign {pci_ad_drv, pci_ad_oe, pci_cbe_drv, pci_cbe_oe} =
         {ad_q, ad_oe_q, cbe_q, cbe_oe_q};
  assign {pci_par_drv, pci_par_oe} = {par_q, par_oe_q};
  assign {pci_frame_n_drv, pci_frame_n_oe}   = {sts_drv[0], sts_oe[0]};
  assign {pci_irdy_n_drv, pci_irdy_n_oe}     = {sts_drv[1], sts_oe[1]};
  assign {pci_trdy_n_drv, pci_trdy_n_oe}     = {sts_drv[2], sts_oe[2]};
  assign {pci_devsel_n_drv, pci_devsel_n_oe} = {sts_drv[3], sts_oe[3]};
  assign {pci_stop_n_drv, pci_stop_n_oe}     = {sts_drv[4], sts_oe[4]};
  assign {pci_lock_n_drv, pci_lock_n_oe}     = {sts_drv[5], sts_oe[5]};
  assign {primary_parity_error_n_drv, primary_parity_error_n_oe} =
         {sts_drv[6], sts_oe[6]};
  // open drain: only ever drives low
  assign {primary_system_error_n_drv, primary_system_error_n_oe} =
         {serr_q, serr_oe_q};
  assign {pci_req_n_drv, pci_req_n_oe} = {req_n_q, req_oe_q};
  assign {speed_66, speed_conflict}    = {spd_q, conf_q};
  assign {mst_ack, mst_rdata, mst_done, mst_abort, mst_stopped} =
         {ack_q, rdata_q, done_q, abort_q, stopped_q};
  assign {cfg_wr, cfg_rd, cfg_reg, cfg_wdata, cfg_be} =
         {cwr_q, crd_q, reg_q, wdata_q, be_q};

  // ***********************************************************
  // checks
  // ***********************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_irdy_hold;
    st_q == ST_M_DATA && !xfer && !m_stop && !m_tmo |=> !pci_irdy_n_drv;
  endproperty
  a_irdy_hold: assert property (p_irdy_hold)
    else $error("irdy dropped inside a data phase");

  property p_tmo;
    st_q == ST_M_ADDR ##1 (pci_devsel_n_bus && st_q != ST_M_TURN)[*5]
      |-> ##[0:2] st_q == ST_M_TURN;
  endproperty
  a_tmo: assert property (p_tmo)
    else $error("no master abort after five unclaimed cycles");

  sequence s_frame_first;
    pci_frame_n_drv && !pci_irdy_n_drv;
  endsequence
  sequence s_irdy_next;
    pci_irdy_n_drv && pci_irdy_n_oe;
  endsequence
  property p_abort_order;
    st_q == ST_M_DATA && !last_q && m_tmo |=> s_frame_first ##1 s_irdy_next;
  endproperty
  a_abort_order: assert property (p_abort_order)
    else $error("abort did not drop frame before irdy");

  property p_cfg_claim;
    st_q == ST_T_DEVSEL |-> $past(primary_config_select) && !pci_devsel_n_drv;
  endproperty
  a_cfg_claim: assert property (p_cfg_claim)
    else $error("claimed without config select");

  property primary_parity_error_n;
    perr_hit |=> !primary_parity_error_n_drv && primary_parity_error_n_oe;
  endproperty
  a_perr: assert property (primary_parity_error_n)
    else $error("parity error not signalled");

  property primary_system_error_n;
    !sec_one_system_error_n |=> primary_system_error_n_oe &&
                                !primary_system_error_n_drv;
  endproperty
  a_serr: assert property (primary_system_error_n)
    else $error("system error not forwarded");

  property p_req_gap;
    $rose(pci_req_n_drv) |=> pci_req_n_drv;
  endproperty
  a_req_gap: assert property (p_req_gap)
    else $error("request reasserted too soon");

  property p_start_gnt;
    st_q == ST_M_ADDR |-> $past(!pci_gnt_n) && !pci_frame_n_drv;
  endproperty
  a_start_gnt: assert property (p_start_gnt)
    else $error("started without grant");

  property p_par;
    pci_ad_oe && pci_cbe_oe |=>
      pci_par_oe && pci_par_drv == ^{$past(pci_ad_drv), $past(pci_cbe_drv)};
  endproperty
  a_par: assert property (p_par)
    else $error("parity wrong or late");

  property p_speed;
    !primary_speed_select_in && sec_two_speed_select_in |=> speed_conflict;
  endproperty
  a_speed: assert property (p_speed)
    else $error("speed conflict not flagged");

  property p_rst_float;
    disable iff (1'h0) rst |-> !pci_ad_oe && !pci_frame_n_oe && !pci_req_n_oe;
  endproperty
  a_rst_float: assert property (p_rst_float)
    else $error("output driven in reset");

endmodule : ppc_port

/* verif/ppc_host_model.sv */
`timescale 1ns/10ps

module ppc_host_model (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // bus levels
  input  wire logic       frame_n,
  input  wire logic       irdy_n,
  input  wire logic       req_n,
  output logic            devsel_n,
  output logic            trdy_n,
  output logic            t_oe,
  output logic            gnt_n,
  // scenario knobs
  input  wire logic       claim,
  input  wire logic       park,
  input  wire logic [1:0] dly
);
  logic [1:0] st_q;
  logic [1:0] cnt_q;
  logic       frame_q;

  // never asks to stop, so the initiator ends by completion or, with claim low, by master abort
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= 2'h0;
      cnt_q <= 2'h0;
      frame_q <= 1'h1;
      devsel_n <= 1'h1;
      trdy_n <= 1'h1;
      t_oe <= 1'h0;
      gnt_n <= 1'h1;
    end else begin
      frame_q <= frame_n;
      gnt_n <= req_n & ~park;  // grant follows request, or is held on while park is set
      case (st_q)
        2'h0: if (!frame_n && frame_q && claim) begin
          cnt_q <= dly;
          st_q <= 2'h1;
        end
        2'h1: if (cnt_q == 2'h0) begin
          devsel_n <= 1'h0;
          trdy_n <= 1'h0;  // held until the last word moves
          t_oe <= 1'h1;
          st_q <= 2'h2;
        end else begin
          cnt_q <= cnt_q - 2'h1;
        end
        2'h2: if (!irdy_n && frame_n) begin  // last word moves
          devsel_n <= 1'h1;  // high one cycle before float
          trdy_n <= 1'h1;
          st_q <= 2'h3;
        end
        default: begin
          t_oe <= 1'h0;
          st_q <= 2'h0;
        end
      endcase
    end
  end
endmodule : ppc_host_model

/* verif/tb_top.sv */
`timescale 1ns/10ps

module tb_top;
  import ppc_pkg::*;

  // ******
  // signals
  // ******
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  int          num_errors = 0;
  int          comparisons = 0;
  int          seed = 32'hec62;
  int          req_gap = 0;
  logic [31:0] pci_ad_drv, mst_rdata, cfg_wdata, cfg_rdata, mst_addr;
  logic [31:0] mst_wdata, h_ad, ad_bus, ad_last = 32'h0;
  logic [3:0]  pci_cbe_drv, mst_cmd, mst_be, cfg_be, h_cbe, cbe_bus;
  logic [3:0]  cbe_last = 4'h0;
  logic [5:0]  serr_event, s_oe, s_drv, s_oe_q, s_drv_q;
  ppc_cfg_reg_t cfg_reg;
  logic pci_ad_oe, pci_cbe_oe, pci_par_drv, pci_par_oe, par_bus;
  logic par_last = 1'b0;
  logic pci_frame_n_drv, pci_frame_n_oe, pci_irdy_n_drv, pci_irdy_n_oe;
  logic pci_trdy_n_drv, pci_trdy_n_oe, pci_devsel_n_drv, pci_devsel_n_oe;
  logic pci_stop_n_drv, pci_stop_n_oe, pci_lock_n_drv, pci_lock_n_oe;
  logic primary_parity_error_n_drv, primary_parity_error_n_oe;
  logic primary_system_error_n_drv, primary_system_error_n_oe;
  logic pci_req_n_drv, pci_req_n_oe, pci_gnt_n, primary_config_select;
  logic primary_speed_select_in, sec_one_speed_select_in, speed_66;
  logic sec_two_speed_select_in, speed_conflict, sec_one_system_error_n;
  logic sec_two_system_error_n, mst_req, mst_last, mst_lock, mst_ack;
  logic mst_done, mst_abort, mst_stopped, cfg_wr, cfg_rd, h_ad_oe;
  logic h_cbe_oe, h_par, h_par_oe, h_frame, h_irdy, h_ctl_oe, h_rd;
  logic m_devsel, m_trdy, m_oe, claim, park, frame_bus, irdy_bus;
  logic trdy_bus, devsel_bus;
  logic [1:0]  dly;
  logic        exp_done_q [$];
  logic [31:0] exp_cfg_q [$];

  // released data lines show junk, control lines have pull-ups
  assign ad_bus = pci_ad_oe ? pci_ad_drv : h_ad_oe ? h_ad : ~ad_last;
  assign cbe_bus = pci_cbe_oe ? pci_cbe_drv : h_cbe_oe ? h_cbe : ~cbe_last;
  assign par_bus = pci_par_oe ? pci_par_drv : h_par_oe ? h_par : ~par_last;
  assign frame_bus = pci_frame_n_oe ? pci_frame_n_drv : ~h_ctl_oe | h_frame;
  assign irdy_bus = pci_irdy_n_oe ? pci_irdy_n_drv : ~h_ctl_oe | h_irdy;
  assign trdy_bus = pci_trdy_n_oe ? pci_trdy_n_drv : ~m_oe | m_trdy;
  assign devsel_bus = pci_devsel_n_oe ? pci_devsel_n_drv : ~m_oe | m_devsel;
  assign s_oe = {pci_frame_n_oe, pci_irdy_n_oe, pci_trdy_n_oe,
                 pci_devsel_n_oe, pci_stop_n_oe, primary_parity_error_n_oe};
  assign s_drv = {pci_frame_n_drv, pci_irdy_n_drv, pci_trdy_n_drv,
                  pci_devsel_n_drv, pci_stop_n_drv, primary_parity_error_n_drv};

  ppc_port dut (
    .pci_ad_bus(ad_bus), .pci_cbe_bus(cbe_bus), .pci_par_bus(par_bus),
    .pci_frame_n_bus(frame_bus), .pci_irdy_n_bus(irdy_bus),
    .pci_trdy_n_bus(trdy_bus), .pci_devsel_n_bus(devsel_bus),
    .pci_stop_n_bus(~pci_stop_n_oe | pci_stop_n_drv),
    .pci_lock_n_bus(~pci_lock_n_oe | pci_lock_n_drv),
    .primary_parity_error_n_bus(s_drv[0] | ~s_oe[0]),
    .primary_system_error_n_bus(~primary_system_error_n_oe), .*);

  ppc_host_model host (.clk_sys(clk_sys), .rst(rst), .frame_n(frame_bus),
    .irdy_n(irdy_bus), .req_n(~pci_req_n_oe | pci_req_n_drv),
    .devsel_n(m_devsel), .trdy_n(m_trdy), .t_oe(m_oe), .gnt_n(pci_gnt_n),
    .claim(claim), .park(park), .dly(dly));

  always #12.5 clk_sys = ~clk_sys;

  // ******
  // checking
  // ******
  task automatic check(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic finish_test;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  always @(posedge clk_sys) begin
    ad_last <= ad_bus;
    cbe_last <= cbe_bus;
    par_last <= par_bus;
    s_oe_q <= rst ? 6'h0 : s_oe;
    s_drv_q <= s_drv;
    if (!rst && pci_par_oe === 1'b1)
      check("par", pci_par_drv, ^{ad_last, cbe_last});
    if (!rst && (s_oe_q & ~s_oe) != 6'h0)
      check("release", s_oe_q & ~s_oe & ~s_drv_q, 6'h0);
    if (mst_done === 1'b1)
      check("abort", mst_abort, exp_done_q.pop_front());
    if (irdy_bus === 1'b0 && trdy_bus === 1'b0 && h_rd === 1'b1)
      check("cfg rdata", ad_bus, exp_cfg_q.pop_front());
    if (irdy_bus === 1'b0 && trdy_bus === 1'b0 && (pci_ad_oe & ~h_rd))
      check("wdata", ad_bus, mst_wdata);
    if (cfg_wr === 1'b1)
      check("cfg wdata", cfg_wdata, exp_cfg_q.pop_front());
    if (pci_req_n_drv !== 1'b0) begin
      req_gap <= req_gap + 1;
    end else begin
      if (req_gap != 0) check("req gap", req_gap >= 2, 1'b1);
      req_gap <= 0;
    end
  end

  // ******
  // stimulus
  // ******
  task automatic mst_op(input logic cl);
    int n;
    int f;
    claim = cl;
    dly = 2'({$random(seed)} % 3);
    mst_addr = $random(seed) & 32'hffff_fffc;
    mst_wdata = $random(seed);
    exp_done_q.push_back(!cl);
    mst_req = 1'b1;
    n = 0;
    f = 0;
    while (mst_done !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      if (frame_bus === 1'b0 || f > 0) f++;
      #1;
      n++;
    end
    check("done", n < 20, 1'b1);
    if (!cl) check("abort time", f >= 5 && f <= 7, 1'b1);
    if (mst_lock) check("lock", {pci_lock_n_oe, pci_lock_n_drv}, 2'h2);
    mst_req = 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : mst_op

  task automatic cfg_acc(input logic wr, sel, bad);
    logic [31:0] d;
    logic        hit;
    int          n;
    d = $random(seed);
    {h_frame, h_ctl_oe, h_ad_oe, h_cbe_oe} = 4'h7;
    h_ad = {24'h0, d[5:0], 2'h0};
    h_cbe = {3'h5, wr};
    primary_config_select = sel;
    cfg_rdata = d;
    if (sel) exp_cfg_q.push_back(d);
    @(posedge clk_sys);
    #1;
    h_par = ^{h_ad, h_cbe};
    {h_par_oe, h_frame, h_irdy, primary_config_select} = 4'hc;
    {h_cbe, h_ad, h_ad_oe, h_rd} = {4'h0, d, wr, !wr};
    hit = 1'b0;
    for (n = 0; n < 8 && !hit; n++) begin
      @(posedge clk_sys);
      hit = (trdy_bus === 1'b0);
      #1;
      h_par = ^{d, 4'h0} ^ bad;
      h_par_oe = wr;
    end
    {h_irdy, h_ad_oe, h_cbe_oe, h_rd} = 4'h8;
    check("claimed", hit, sel);
    hit = 1'b0;
    repeat (5) begin
      @(posedge clk_sys);
      #1;
      {h_ctl_oe, h_par_oe} = 2'h0;
      hit |= s_oe[0] === 1'b1 && s_drv[0] === 1'b0;
    end
    check("perr", hit, wr && sel && bad);
    if (bad) exp_cfg_q.delete();
  endtask : cfg_acc

  initial begin
    {mst_req, mst_last, mst_lock, primary_config_select} = 4'h4;
    {mst_cmd, mst_be, mst_addr, mst_wdata, cfg_rdata} = {4'h7, 100'h0};
    {primary_speed_select_in, sec_one_speed_select_in} = 2'h0;
    {sec_two_speed_select_in, serr_event} = 7'h0;
    {sec_one_system_error_n, sec_two_system_error_n} = 2'h3;
    {h_ad_oe, h_cbe_oe, h_par_oe, h_ctl_oe, h_frame, h_irdy} = 6'h3;
    {h_ad, h_cbe, h_par, claim, park, dly, h_rd} = 42'h0;
    repeat (8) @(posedge clk_sys);
    #1 rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      {primary_speed_select_in, sec_one_speed_select_in,
       sec_two_speed_select_in} = i[2:0];
      repeat (2) @(posedge clk_sys);
      #1;
      check("speed_66", speed_66, i[2]);
      check("conflict", speed_conflict, !i[2] && i[1:0] != 0);
    end
    for (int i = 0; i < 8; i++) begin
      serr_event = 6'(7'h1 << i);
      {sec_one_system_error_n, sec_two_system_error_n} = {i != 6, i != 7};
      repeat (3) @(posedge clk_sys);
      #1;
      check("serr", {primary_system_error_n_oe, primary_system_error_n_drv}, 2'h2);
      serr_event = 6'h0;
      {sec_one_system_error_n, sec_two_system_error_n} = 2'h3;
      repeat (4) @(posedge clk_sys);
      #1;
      check("serr idle", primary_system_error_n_oe, 1'b0);
    end
    park = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    check("park", {pci_ad_oe, pci_cbe_oe}, 2'h3);
    for (int k = 0; k < 6; k++) begin
      park = k[0];
      mst_lock = (k == 1);
      mst_last = (k != 4);
      mst_op(k != 2 && k != 4);
    end
    {claim, park, mst_lock} = 3'h0;
    repeat (3) @(posedge clk_sys);
    #1;
    for (int i = 0; i < 5; i++) begin
      cfg_acc(i[0], i < 4, i == 3);
    end
    park = 1'b1;
    repeat (4) @(posedge clk_sys);
    #5 rst = 1'b1;
    #1;
    check("reset float", {s_oe, pci_ad_oe, pci_cbe_oe, pci_par_oe, pci_lock_n_oe,
      primary_system_error_n_oe, pci_req_n_oe}, 12'h0);
    repeat (2) @(posedge clk_sys);
    #1 rst = 1'b0;
    mst_op(1'b1);
    finish_test();
  end

  // run needs well under 1000 cycles; allow ample margin
  initial begin
    #50us;
    num_errors++;
    finish_test();
  end
endmodule : tb_top
